/* src/sfd_link_select_map.svh */
`ifndef SFD_LINK_SELECT_MAP_SVH
`define SFD_LINK_SELECT_MAP_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define SFD_OFF_RST 16'h0000
`define SFD_VAL_RST 32'h0000_0000
`define SFD_WORD_RST 16'h0000

// ****************************************************************
// Offset layout in the link output area
// ****************************************************************
`define SFD_WORD_SPAN 2
`define SFD_HI_WORD 16'h0001
`define SFD_OUT_LIMIT_DEF 32'h0000_0200

// ****************************************************************
// Timing
// ****************************************************************
`define SFD_CLK_PERIOD_NS 10
`define SFD_CTRL_PERIOD_NS 1000000
`define SFD_CTRL_CYC (`SFD_CTRL_PERIOD_NS / `SFD_CLK_PERIOD_NS)

`endif

/* src/sfd_pkg.sv */
package sfd_pkg;

    // ****************************************************************
    // Basic types
    // ****************************************************************
    typedef logic [15:0] sfd_off_t;
    typedef logic [15:0] sfd_word_t;
    typedef logic [31:0] sfd_val_t;

    // Feeding command that is executing
    typedef enum logic [1:0] {
        SFD_MODE_NONE = 2'h0,
        SFD_MODE_POS = 2'h1,
        SFD_MODE_VEL = 2'h2,
        SFD_MODE_TRQ = 2'h3
    } sfd_mode_t;

    // Torque option selector codes
    typedef enum logic [2:0] {
        SFD_OPT_NONE = 3'h0,
        SFD_OPT_FF_LIM = 3'h1,
        SFD_OPT_FF = 3'h2,
        SFD_OPT_LIM = 3'h3,
        SFD_OPT_POS_NEG = 3'h4
    } sfd_opt_t;

    // Position master selector codes
    typedef enum logic [2:0] {
        SFD_MST_NONE = 3'h0,
        SFD_MST_FB = 3'h3,
        SFD_MST_CMD = 3'h4
    } sfd_mst_t;

    // Source fetched from the link area, in fetch order
    typedef enum logic [2:0] {
        SFD_IT_VEL = 3'h0,
        SFD_IT_TRQ = 3'h1,
        SFD_IT_OPT = 3'h2,
        SFD_IT_VLIM = 3'h3,
        SFD_IT_AUX = 3'h4
    } sfd_item_t;

    // Live selection settings
    typedef struct packed {
        logic vel_sel;
        sfd_off_t vel_off;
        logic trq_sel;
        sfd_off_t trq_off;
        logic [2:0] opt_sel;
        sfd_off_t opt_off;
        logic vlim_sel;
        sfd_off_t vlim_off;
        logic aux_sel;
        sfd_off_t aux_off;
        logic [2:0] mst_sel;
    } sfd_cfg_t;

    // Decoded torque options
    typedef struct packed {
        logic ff_en;
        logic lim_en;
        sfd_word_t ff;
        sfd_word_t lim_pos;
        sfd_word_t lim_neg;
    } sfd_topt_t;

endpackage : sfd_pkg

/* src/sfd_link_select.sv */
`timescale 1ns/1ns
`include "sfd_link_select_map.svh"

module sfd_link_select #(
    parameter int unsigned OUT_LIMIT = `SFD_OUT_LIMIT_DEF,
    parameter int unsigned CTRL_CYC = `SFD_CTRL_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Command state and live settings
    input wire sfd_pkg::sfd_mode_t mode,
    input wire sfd_pkg::sfd_cfg_t cfg,
    // Servo axis positions for the electric shaft
    input wire sfd_pkg::sfd_val_t fb_pos,
    input wire sfd_pkg::sfd_val_t cmd_pos,
    // Link output area read port, one cycle latency
    output logic link_rd,
    output sfd_pkg::sfd_off_t link_addr,
    input wire sfd_pkg::sfd_word_t link_rdata,
    // Fetched command values
    output sfd_pkg::sfd_val_t cmd_vel,
    output sfd_pkg::sfd_val_t cmd_trq,
    output sfd_pkg::sfd_topt_t topt,
    output logic vlim_en,
    output sfd_pkg::sfd_val_t vlim,
    output logic aux_en,
    output sfd_pkg::sfd_val_t aux_pos,
    output sfd_pkg::sfd_val_t slave_pos,
    // Status
    output logic [4:0] src_valid,
    output logic [5:0] cfg_err,
    output logic busy,
    output logic update
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    typedef enum logic [2:0] {S_IDLE, S_PICK, S_LO, S_HI, S_CAP, S_DONE} sfd_state_t;
    sfd_state_t state_r;
    sfd_pkg::sfd_item_t item_r;
    logic [31:0] div_r;
    logic tick_r;
    sfd_pkg::sfd_word_t lo_r;
    sfd_pkg::sfd_word_t opt1_r;
    sfd_pkg::sfd_word_t opt2_r;
    logic link_rd_r;
    sfd_pkg::sfd_off_t link_addr_r;
    sfd_pkg::sfd_val_t cmd_vel_r;
    sfd_pkg::sfd_val_t cmd_trq_r;
    sfd_pkg::sfd_topt_t topt_r;
    logic vlim_en_r;
    sfd_pkg::sfd_val_t vlim_r;
    logic aux_en_r;
    sfd_pkg::sfd_val_t aux_pos_r;
    sfd_pkg::sfd_val_t slave_pos_r;
    logic [4:0] src_valid_r;
    logic [5:0] cfg_err_r;
    logic busy_r;
    logic update_r;
    logic cur_en;
    logic cur_err;
    sfd_pkg::sfd_off_t cur_off;
    sfd_pkg::sfd_val_t fetched;
    sfd_pkg::sfd_val_t aux_add;

    // Offset fits a two-word value inside the output size limit
    function automatic logic off_ok(input sfd_pkg::sfd_off_t off);
        off_ok = (32'(off) + 32'(`SFD_WORD_SPAN)) <= OUT_LIMIT;
    endfunction : off_ok

    // ****************************************************************
    // Source enable decode for the item being considered
    // ****************************************************************
    // Selectors and offsets are sampled live at each fetch
    always_comb begin
        cur_en = 1'b0;
        cur_err = 1'b0;
        cur_off = `SFD_OFF_RST;
        unique case (item_r)
            sfd_pkg::SFD_IT_VEL: begin
                cur_off = cfg.vel_off;
                cur_err = cfg.vel_sel && !off_ok(cfg.vel_off);
                cur_en = (mode == sfd_pkg::SFD_MODE_VEL) && cfg.vel_sel && !cur_err;
            end
            sfd_pkg::SFD_IT_TRQ: begin
                cur_off = cfg.trq_off;
                cur_err = cfg.trq_sel && !off_ok(cfg.trq_off);
                cur_en = (mode == sfd_pkg::SFD_MODE_TRQ) && cfg.trq_sel && !cur_err;
            end
            sfd_pkg::SFD_IT_OPT: begin
                cur_off = cfg.opt_off;
                cur_err = (cfg.opt_sel > sfd_pkg::SFD_OPT_POS_NEG)
                    || ((cfg.opt_sel != sfd_pkg::SFD_OPT_NONE) && !off_ok(cfg.opt_off));
                cur_en = ((mode == sfd_pkg::SFD_MODE_POS) || (mode == sfd_pkg::SFD_MODE_VEL))
                    && (cfg.opt_sel != sfd_pkg::SFD_OPT_NONE) && !cur_err;
            end
            sfd_pkg::SFD_IT_VLIM: begin
                cur_off = cfg.vlim_off;
                cur_err = cfg.vlim_sel && !off_ok(cfg.vlim_off);
                cur_en = (mode == sfd_pkg::SFD_MODE_TRQ) && cfg.vlim_sel && !cur_err;
            end
            sfd_pkg::SFD_IT_AUX: begin
                cur_off = cfg.aux_off;
                cur_err = cfg.aux_sel && !off_ok(cfg.aux_off);
                cur_en = (mode == sfd_pkg::SFD_MODE_POS) && cfg.aux_sel && !cur_err;
            end
            default: cur_en = 1'b0;
        endcase
    end

    // Two captured words form one value, first word is the low half
    assign fetched = {link_rdata, lo_r};
    // Auxiliary correction only while its value is valid
    assign aux_add = src_valid_r[sfd_pkg::SFD_IT_AUX] ? aux_pos_r : `SFD_VAL_RST;

    // ****************************************************************
    // Control cycle divider
    // ****************************************************************
    // One-cycle tick per control period
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            div_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else if (div_r >= CTRL_CYC - 1) begin
            div_r <= 32'h0000_0000;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 32'h0000_0001;
            tick_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Fetch sequencer
    // ****************************************************************
    // Walks all sources once per control cycle while a command runs
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            item_r <= sfd_pkg::SFD_IT_VEL;
            lo_r <= `SFD_WORD_RST;
            link_rd_r <= 1'b0;
            link_addr_r <= `SFD_OFF_RST;
            busy_r <= 1'b0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (tick_r && (mode != sfd_pkg::SFD_MODE_NONE)) begin
                        item_r <= sfd_pkg::SFD_IT_VEL;
                        busy_r <= 1'b1;
                        state_r <= S_PICK;
                    end
                end
                S_PICK: begin
                    if (cur_en) begin
                        link_addr_r <= cur_off;
                        link_rd_r <= 1'b1;
                        state_r <= S_LO;
                    end else if (item_r == sfd_pkg::SFD_IT_AUX) begin
                        state_r <= S_DONE;
                    end else begin
                        item_r <= sfd_pkg::sfd_item_t'(item_r + 3'h1);
                    end
                end
                S_LO: begin
                    link_addr_r <= link_addr_r + `SFD_HI_WORD;
                    state_r <= S_HI;
                end
                S_HI: begin
                    link_rd_r <= 1'b0;
                    lo_r <= link_rdata;
                    state_r <= S_CAP;
                end
                S_CAP: begin
                    if (item_r == sfd_pkg::SFD_IT_AUX) begin
                        state_r <= S_DONE;
                    end else begin
                        item_r <= sfd_pkg::sfd_item_t'(item_r + 3'h1);
                        state_r <= S_PICK;
                    end
                end
                S_DONE: begin
                    busy_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Source validity and setting errors
    // ****************************************************************
    // A source is valid from its capture until it is found disabled
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            src_valid_r <= 5'h00;
            cfg_err_r <= 6'h00;
        end else if (state_r == S_PICK) begin
            cfg_err_r[item_r] <= cur_err;
            if (!cur_en) begin
                src_valid_r[item_r] <= 1'b0;
            end
        end else if (state_r == S_CAP) begin
            src_valid_r[item_r] <= 1'b1;
        end else if (state_r == S_DONE) begin
            cfg_err_r[5] <= (cfg.mst_sel != sfd_pkg::SFD_MST_NONE)
                && (cfg.mst_sel != sfd_pkg::SFD_MST_FB)
                && (cfg.mst_sel != sfd_pkg::SFD_MST_CMD);
        end
    end

    // ****************************************************************
    // Captured values
    // ****************************************************************
    // Store each fetched value into its own target
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cmd_vel_r <= `SFD_VAL_RST;
            cmd_trq_r <= `SFD_VAL_RST;
            opt1_r <= `SFD_WORD_RST;
            opt2_r <= `SFD_WORD_RST;
            vlim_r <= `SFD_VAL_RST;
            aux_pos_r <= `SFD_VAL_RST;
        end else if (state_r == S_CAP) begin
            unique case (item_r)
                sfd_pkg::SFD_IT_VEL: cmd_vel_r <= fetched;
                sfd_pkg::SFD_IT_TRQ: cmd_trq_r <= fetched;
                sfd_pkg::SFD_IT_OPT: begin
                    opt1_r <= lo_r;
                    opt2_r <= link_rdata;
                end
                sfd_pkg::SFD_IT_VLIM: vlim_r <= fetched;
                sfd_pkg::SFD_IT_AUX: aux_pos_r <= fetched;
                default: cmd_vel_r <= cmd_vel_r;
            endcase
        end
    end

    // ****************************************************************
    // Option decode and position sum at end of sequence
    // ****************************************************************
    // Torque option usage from the live code
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            topt_r <= '0;
        end else if (state_r == S_DONE) begin
            topt_r <= '0;
            if (src_valid_r[sfd_pkg::SFD_IT_OPT]) begin
                unique case (cfg.opt_sel)
                    sfd_pkg::SFD_OPT_FF_LIM: begin
                        topt_r.ff_en <= 1'b1;
                        topt_r.lim_en <= 1'b1;
                        topt_r.ff <= opt1_r;
                        topt_r.lim_pos <= opt2_r;
                        topt_r.lim_neg <= opt2_r;
                    end
                    sfd_pkg::SFD_OPT_FF: begin
                        topt_r.ff_en <= 1'b1;
                        topt_r.ff <= opt1_r;
                    end
                    sfd_pkg::SFD_OPT_LIM: begin
                        topt_r.lim_en <= 1'b1;
                        topt_r.lim_pos <= opt2_r;
                        topt_r.lim_neg <= opt2_r;
                    end
                    sfd_pkg::SFD_OPT_POS_NEG: begin
                        topt_r.lim_en <= 1'b1;
                        topt_r.lim_pos <= opt1_r;
                        topt_r.lim_neg <= opt2_r;
                    end
                    default: topt_r.ff_en <= 1'b0;
                endcase
            end
        end
    end

    // Electric shaft slave position with auxiliary correction
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slave_pos_r <= `SFD_VAL_RST;
            vlim_en_r <= 1'b0;
            aux_en_r <= 1'b0;
            update_r <= 1'b0;
        end else begin
            update_r <= (state_r == S_DONE);
            if (state_r == S_DONE) begin
                vlim_en_r <= src_valid_r[sfd_pkg::SFD_IT_VLIM];
                aux_en_r <= src_valid_r[sfd_pkg::SFD_IT_AUX];
                if (mode == sfd_pkg::SFD_MODE_POS) begin
                    unique case (cfg.mst_sel)
                        sfd_pkg::SFD_MST_FB: slave_pos_r <= fb_pos + aux_add;
                        sfd_pkg::SFD_MST_CMD: slave_pos_r <= cmd_pos + aux_add;
                        default: slave_pos_r <= slave_pos_r;
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link_rd = link_rd_r;
    assign link_addr = link_addr_r;
    assign cmd_vel = cmd_vel_r;
    assign cmd_trq = cmd_trq_r;
    assign topt = topt_r;
    assign vlim_en = vlim_en_r;
    assign vlim = vlim_r;
    assign aux_en = aux_en_r;
    assign aux_pos = aux_pos_r;
    assign slave_pos = slave_pos_r;
    assign src_valid = src_valid_r;
    assign cfg_err = cfg_err_r;
    assign busy = busy_r;
    assign update = update_r;

endmodule : sfd_link_select

/* testbench/sfd_link_mem.sv */
`timescale 1ns/1ns
module sfd_link_mem (
    // Clock
    input wire logic ref_clk,
    // Link output area read port
    input wire logic link_rd,
    input wire sfd_pkg::sfd_off_t link_addr,
    output sfd_pkg::sfd_word_t link_rdata
);
    // ****************************************************************
    // Link output area
    // ****************************************************************
    // Each word is its index xor a mask, so any address slip shows
    initial link_rdata = 16'h0000;
    // Idle cycles invert the bus so stale data never looks valid
    always @(posedge ref_clk) begin
        if (link_rd) begin
            link_rdata <= link_addr ^ 16'hC3C3;
        end else begin
            link_rdata <= ~link_rdata;
        end
    end
endmodule : sfd_link_mem

/* testbench/sfd_link_select_sva.sv */
`timescale 1ns/1ns
module sfd_link_select_sva #(
    parameter int unsigned OUT_LIMIT = 512,
    parameter int unsigned CTRL_CYC = 100000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Watched ports
    input wire sfd_pkg::sfd_mode_t mode,
    input wire sfd_pkg::sfd_cfg_t cfg,
    input wire sfd_pkg::sfd_val_t fb_pos,
    input wire logic link_rd,
    input wire sfd_pkg::sfd_off_t link_addr,
    input wire sfd_pkg::sfd_topt_t topt,
    input wire logic vlim_en,
    input wire logic aux_en,
    input wire sfd_pkg::sfd_val_t aux_pos,
    input wire sfd_pkg::sfd_val_t slave_pos,
    input wire logic [4:0] src_valid,
    input wire logic busy,
    input wire logic update
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    // All checks run on the one clock and rest during reset
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_read_pair: assert property (
        $rose(link_rd) |=> link_rd ##1 !link_rd) else $error("Link read is not two words");
    a_addr_next: assert property (
        $rose(link_rd) |=> link_addr == $past(link_addr) + 16'h0001)
        else $error("Second word not at next address");
    a_addr_range: assert property (
        $rose(link_rd) |-> 32'(link_addr) + 2 <= OUT_LIMIT) else $error("Read beyond limit");
    a_seq_bound: assert property (
        $rose(busy) |-> ##[6:30] update) else $error("Fetch sequence too long");
    a_upd_idle: assert property (
        update |-> !busy ##1 !update) else $error("Update not a single idle pulse");
    a_vel_mode: assert property (
        $rose(src_valid[0]) |-> mode == sfd_pkg::SFD_MODE_VEL) else $error("Velocity fetched");
    a_vlim_mode: assert property (
        $rose(vlim_en) |-> $past(mode) == sfd_pkg::SFD_MODE_TRQ)
        else $error("Limit used off torque");
    a_aux_mode: assert property (
        $rose(aux_en) |-> $past(mode) == sfd_pkg::SFD_MODE_POS)
        else $error("Aux used off position");
    a_opt_trq: assert property (
        update && $past(mode) == sfd_pkg::SFD_MODE_TRQ |-> !topt.ff_en && !topt.lim_en)
        else $error("Torque options used in torque feeding");
    a_slave_sum: assert property (
        update && aux_en && $past(mode) == sfd_pkg::SFD_MODE_POS
        && $past(cfg.mst_sel) == 3'h3
        |-> slave_pos == $past(fb_pos) + aux_pos) else $error("Slave position not master plus aux");
endmodule : sfd_link_select_sva

bind sfd_link_select sfd_link_select_sva #(.OUT_LIMIT(OUT_LIMIT), .CTRL_CYC(CTRL_CYC))
    i_sfd_link_select_sva (.ref_clk, .resetn, .mode, .cfg, .fb_pos, .link_rd, .link_addr,
    .topt, .vlim_en, .aux_en, .aux_pos, .slave_pos, .src_valid, .busy, .update);

/* testbench/sfd_link_select_tb.sv */
`timescale 1ns/1ns
`define SFD_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module sfd_link_select_tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam int unsigned LIM = 64;
    localparam int unsigned CYC = 40;
    logic ref_clk;
    logic resetn;
    sfd_pkg::sfd_mode_t mode;
    sfd_pkg::sfd_cfg_t cfg;
    sfd_pkg::sfd_val_t fb_pos;
    sfd_pkg::sfd_val_t cmd_pos;
    logic link_rd;
    sfd_pkg::sfd_off_t link_addr;
    sfd_pkg::sfd_word_t link_rdata;
    sfd_pkg::sfd_val_t cmd_vel;
    sfd_pkg::sfd_val_t cmd_trq;
    sfd_pkg::sfd_topt_t topt;
    logic vlim_en;
    sfd_pkg::sfd_val_t vlim;
    logic aux_en;
    sfd_pkg::sfd_val_t aux_pos;
    sfd_pkg::sfd_val_t slave_pos;
    logic [4:0] src_valid;
    logic [5:0] cfg_err;
    logic busy;
    logic update;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc_cnt = 0;

    // Block under test and link area model
    sfd_link_select #(.OUT_LIMIT(LIM), .CTRL_CYC(CYC)) i_sfd_link_select (.ref_clk, .resetn,
        .mode, .cfg, .fb_pos, .cmd_pos, .link_rd, .link_addr, .link_rdata, .cmd_vel, .cmd_trq,
        .topt, .vlim_en, .vlim, .aux_en, .aux_pos, .slave_pos, .src_valid, .cfg_err, .busy,
        .update);
    sfd_link_mem i_sfd_link_mem (.ref_clk, .link_rd, .link_addr, .link_rdata);

    // Clock and hang guard
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Expected link words, same pattern as the area model
    function automatic sfd_pkg::sfd_word_t wd(input int unsigned o);
        return 16'(o) ^ 16'hC3C3;
    endfunction : wd
    function automatic sfd_pkg::sfd_val_t dval(input int unsigned o);
        return {wd(o + 1), wd(o)};
    endfunction : dval
    // Waits on falling edges for the next update pulse
    task automatic wait_upd();
        int i = 0;
        @(negedge ref_clk);
        while (update !== 1'b1 && i < 200) begin
            @(negedge ref_clk);
            i++;
        end
        `SFD_CHK("update", 1'b1, update)
    endtask : wait_upd
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Idle after reset, nothing starts with no command
    task automatic t_idle();
        int seen = 0;
        `SFD_CHK("src_valid", 5'h00, src_valid)
        `SFD_CHK("cfg_err", 6'h00, cfg_err)
        repeat (3 * CYC) begin
            @(negedge ref_clk);
            if (busy !== 1'b0) seen++;
        end
        `SFD_CHK("idle busy", 0, seen)
        $display("done t_idle");
    endtask : t_idle
    // Velocity feeding with feed forward option, other sources set but out of mode
    task automatic t_vel();
        mode = sfd_pkg::SFD_MODE_VEL;
        cfg.vel_sel = 1'b1;
        cfg.vel_off = 16'h0005;
        cfg.trq_sel = 1'b1;
        cfg.vlim_sel = 1'b1;
        cfg.aux_sel = 1'b1;
        cfg.opt_sel = 3'h2;
        cfg.opt_off = 16'h0009;
        wait_upd();
        `SFD_CHK("cmd_vel", dval(5), cmd_vel)
        `SFD_CHK("src_valid", 5'h05, src_valid)
        `SFD_CHK("ff", wd(9), topt.ff)
        `SFD_CHK("vlim_en", 1'b0, vlim_en)
        `SFD_CHK("aux_en", 1'b0, aux_en)
        cfg.vel_off = 16'h0014;
        wait_upd();
        `SFD_CHK("cmd_vel live", dval(20), cmd_vel)
        $display("done t_vel");
    endtask : t_vel
    // Torque feeding with limit, then both sources switched off
    task automatic t_trq();
        mode = sfd_pkg::SFD_MODE_TRQ;
        cfg.trq_off = 16'h001E;
        cfg.vlim_off = 16'h0028;
        cfg.opt_sel = 3'h1;
        wait_upd();
        `SFD_CHK("cmd_trq", dval(30), cmd_trq)
        `SFD_CHK("vlim", dval(40), vlim)
        `SFD_CHK("vlim_en", 1'b1, vlim_en)
        `SFD_CHK("opt en", 2'b00, {topt.ff_en, topt.lim_en})
        `SFD_CHK("src_valid", 5'h0A, src_valid)
        cfg.trq_sel = 1'b0;
        cfg.vlim_sel = 1'b0;
        wait_upd();
        `SFD_CHK("src_valid off", 5'h00, src_valid)
        `SFD_CHK("vlim_en off", 1'b0, vlim_en)
        $display("done t_trq");
    endtask : t_trq
    // Position feeding, aux at the last legal offset, both masters
    task automatic t_pos();
        mode = sfd_pkg::SFD_MODE_POS;
        cfg.vlim_sel = 1'b1;
        cfg.aux_off = 16'h003E;
        cfg.mst_sel = 3'h3;
        cfg.opt_sel = 3'h4;
        cfg.opt_off = 16'h0000;
        wait_upd();
        `SFD_CHK("aux_pos", dval(62), aux_pos)
        `SFD_CHK("aux_en", 1'b1, aux_en)
        `SFD_CHK("slave fb", fb_pos + dval(62), slave_pos)
        `SFD_CHK("lim_pos", wd(0), topt.lim_pos)
        `SFD_CHK("lim_neg", wd(1), topt.lim_neg)
        `SFD_CHK("src_valid", 5'h14, src_valid)
        cfg.mst_sel = 3'h4;
        wait_upd();
        `SFD_CHK("slave cmd", cmd_pos + dval(62), slave_pos)
        cfg.mst_sel = 3'h0;
        wait_upd();
        `SFD_CHK("slave hold", cmd_pos + dval(62), slave_pos)
        $display("done t_pos");
    endtask : t_pos
    // Every torque option code in velocity feeding
    task automatic t_opt();
        mode = sfd_pkg::SFD_MODE_VEL;
        cfg.opt_off = 16'h0020;
        for (int k = 0; k < 5; k++) begin
            cfg.opt_sel = 3'(k);
            wait_upd();
            `SFD_CHK("ff_en", 1'(k == 1 || k == 2), topt.ff_en)
            `SFD_CHK("lim_en", 1'(k == 1 || k > 2), topt.lim_en)
            if (k == 1 || k == 2) `SFD_CHK("ff", wd(32), topt.ff)
            if (k == 1 || k > 2) `SFD_CHK("lim_neg", wd(33), topt.lim_neg)
            if (k != 0 && k != 2) `SFD_CHK("lim_pos", wd(k == 4 ? 32 : 33), topt.lim_pos)
        end
        $display("done t_opt");
    endtask : t_opt
    // Offset past the limit, bad option and master codes
    task automatic t_bad();
        mode = sfd_pkg::SFD_MODE_POS;
        cfg.aux_off = 16'h003F;
        cfg.opt_sel = 3'h5;
        cfg.mst_sel = 3'h1;
        wait_upd();
        `SFD_CHK("err aux", 1'b1, cfg_err[4])
        `SFD_CHK("aux valid", 1'b0, src_valid[4])
        `SFD_CHK("err opt", 1'b1, cfg_err[2])
        `SFD_CHK("err mst", 1'b1, cfg_err[5])
        $display("done t_bad");
    endtask : t_bad

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        mode = sfd_pkg::SFD_MODE_NONE;
        cfg = '0;
        fb_pos = 32'h0001_0000;
        cmd_pos = 32'h0200_0000;
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        t_idle();
        t_vel();
        t_trq();
        t_pos();
        t_opt();
        t_bad();
        tally_and_finish();
    end
endmodule : sfd_link_select_tb
